// [hw/pscp_device.sv]
`timescale 1ns/1ns
`default_nettype none
module pscp_device #(
    parameter int STORE_CYCLES = pscp_pkg::STORE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    pscp_if.dev link,
    input wire logic reload_strobe_n,
    output logic [pscp_pkg::WIPER_W-1:0] wiper,
    output logic latched_out_one,
    output logic latched_out_two,
    output logic store_busy,
    output logic store_done_n
);
    typedef enum logic [1:0] {
        PSCP_ST_IDLE = 2'b01,
        PSCP_ST_STORE = 2'b10
    } pscp_state_t;

    typedef logic [pscp_pkg::NVS_W-1:0] pscp_nvs_t [pscp_pkg::NVS_DEPTH];

    localparam int I_CS = 0;
    localparam int I_CLK = 1;
    localparam int I_SDI = 2;
    localparam int I_WP = 3;
    localparam int I_PR = 4;

    function automatic logic [9:0] pscp_step(input logic [9:0] w, input logic up);
        if (up) begin
            pscp_step = (w == pscp_pkg::WIPER_MAX) ? w : w + 10'h001;
        end else begin
            pscp_step = (w == 10'h000) ? w : w - 10'h001;
        end
    endfunction : pscp_step

    function automatic logic [9:0] pscp_shift(input logic [9:0] w, input logic up);
        if (up) begin
            pscp_shift = w[9] ? pscp_pkg::WIPER_MAX : {w[8:0], 1'b0};
        end else begin
            pscp_shift = {1'b0, w[9:1]};
        end
    endfunction : pscp_shift

    logic [4:0] lvl, prev_ff;
    logic cs_fall, cs_rise, clk_rise, clk_fall, pr_rise;

    pscp_sync #(
        .W(5),
        .INIT(5'h1B)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin({reload_strobe_n, link.wp_n, link.sdi, link.sclk, link.cs_n}),
        .level(lvl)
    );

    assign cs_fall = prev_ff[I_CS] & ~lvl[I_CS];
    assign cs_rise = ~prev_ff[I_CS] & lvl[I_CS];
    assign clk_rise = ~prev_ff[I_CLK] & lvl[I_CLK];
    assign clk_fall = prev_ff[I_CLK] & ~lvl[I_CLK];
    assign pr_rise = ~prev_ff[I_PR] & lvl[I_PR];

    logic [pscp_pkg::WORD_BITS-1:0] sr_ff, nxt_sr, last_ff, nxt_last, word;
    logic [pscp_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic seen_ff, nxt_seen, have_ff, nxt_have, boot_ff, sdo_ff, nxt_sdo;
    logic done_n_ff, nxt_done_n, exec;
    logic [9:0] wiper_ff, nxt_wiper;
    pscp_nvs_t nvs_ff, nxt_nvs;
    pscp_state_t state_ff, nxt_state;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [3:0] cmd, adr;
    logic [15:0] dat;

    // chosen from the select edge, not from exec, so the decoder never loops back on itself
    assign word = (cs_rise && !seen_ff) ? last_ff : sr_ff;
    assign cmd = word[pscp_pkg::CMD_MSB:pscp_pkg::CMD_LSB];
    assign adr = word[pscp_pkg::ADR_MSB:pscp_pkg::ADR_LSB];
    assign dat = word[pscp_pkg::DAT_MSB:0];

    always_comb begin
        nxt_sr = sr_ff;
        nxt_cnt = cnt_ff;
        nxt_seen = seen_ff;
        nxt_sdo = sdo_ff;
        nxt_last = last_ff;
        nxt_have = have_ff;
        nxt_wiper = wiper_ff;
        nxt_nvs = nvs_ff;
        nxt_state = state_ff;
        nxt_tmr = tmr_ff;
        nxt_done_n = 1'b1;
        exec = 1'b0;
        if (boot_ff) begin
            nxt_wiper = nvs_ff[0][9:0];
        end
        case (state_ff)
            PSCP_ST_STORE: begin
                // shifter and decoder are locked for the whole store
                if (tmr_ff == 32'h0) begin
                    nxt_state = PSCP_ST_IDLE;
                    nxt_done_n = 1'b0;
                end else begin
                    nxt_tmr = tmr_ff - 32'h1;
                end
            end
            PSCP_ST_IDLE: begin
                if (!lvl[I_CS]) begin
                    // mode 0,0 and 1,1 both sample on rising, shift out on falling
                    if (cs_fall || clk_fall) begin
                        nxt_sdo = sr_ff[pscp_pkg::WORD_BITS-1];
                    end
                    if (clk_rise) begin
                        nxt_sr = {sr_ff[pscp_pkg::WORD_BITS-2:0], lvl[I_SDI]};
                        nxt_seen = 1'b1;
                        nxt_cnt = (cnt_ff == 5'(pscp_pkg::WORD_BITS - 1)) ? '0 : cnt_ff + 5'h01;
                    end
                end else if (cs_rise) begin
                    nxt_cnt = '0;
                    nxt_seen = 1'b0;
                    if (!seen_ff) begin
                        exec = have_ff;
                    end else if ((cnt_ff & 5'(pscp_pkg::NIBBLE_MASK)) != 5'h00) begin
                        exec = 1'b0;
                    end else begin
                        exec = (cnt_ff == 5'h00);
                    end
                end
            end
            default: nxt_state = PSCP_ST_IDLE;
        endcase
        if (exec) begin
            nxt_have = 1'b1;
            nxt_last = word;
            case (cmd)
                pscp_pkg::CMD_RESTORE, pscp_pkg::CMD_RESET: begin
                    nxt_wiper = nvs_ff[0][9:0];
                end
                pscp_pkg::CMD_STORE_WIPER: begin
                    if (lvl[I_WP]) begin
                        nxt_nvs[0] = {6'h00, wiper_ff};
                        nxt_state = PSCP_ST_STORE;
                        nxt_tmr = 32'(STORE_CYCLES - 1);
                    end
                end
                pscp_pkg::CMD_STORE_DATA: begin
                    if (lvl[I_WP]) begin
                        nxt_nvs[adr] = dat;
                        nxt_state = PSCP_ST_STORE;
                        nxt_tmr = 32'(STORE_CYCLES - 1);
                    end
                end
                pscp_pkg::CMD_DEC6_A, pscp_pkg::CMD_DEC6_B: begin
                    if (lvl[I_WP]) nxt_wiper = pscp_shift(wiper_ff, 1'b0);
                end
                pscp_pkg::CMD_DEC1_A, pscp_pkg::CMD_DEC1_B: begin
                    if (lvl[I_WP]) nxt_wiper = pscp_step(wiper_ff, 1'b0);
                end
                pscp_pkg::CMD_INC6_A, pscp_pkg::CMD_INC6_B: begin
                    if (lvl[I_WP]) nxt_wiper = pscp_shift(wiper_ff, 1'b1);
                end
                pscp_pkg::CMD_INC1_A, pscp_pkg::CMD_INC1_B: begin
                    if (lvl[I_WP]) nxt_wiper = pscp_step(wiper_ff, 1'b1);
                end
                pscp_pkg::CMD_READ_NVS: begin
                    nxt_sr[pscp_pkg::DAT_MSB:0] = nvs_ff[adr];
                end
                pscp_pkg::CMD_READ_WIPER: begin
                    nxt_sr[pscp_pkg::DAT_MSB:0] = {6'h00, wiper_ff};
                end
                pscp_pkg::CMD_WRITE_WIPER: begin
                    if (lvl[I_WP] && adr == 4'h0) begin
                        nxt_wiper = dat[pscp_pkg::WIPER_W-1:0];
                    end
                end
                default: nxt_have = 1'b1;
            endcase
        end
        // the strobe overrides any wiper change the serial port made this cycle
        if (!lvl[I_PR]) begin
            nxt_wiper = pscp_pkg::WIPER_MID;
        end else if (pr_rise) begin
            nxt_wiper = nvs_ff[0][9:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prev_ff <= 5'h1B;
            sr_ff <= '0;
            cnt_ff <= '0;
            seen_ff <= 1'b0;
            sdo_ff <= 1'b1;
            last_ff <= '0;
            have_ff <= 1'b0;
            boot_ff <= 1'b1;
            wiper_ff <= pscp_pkg::WIPER_MID;
            state_ff <= PSCP_ST_IDLE;
            tmr_ff <= '0;
            done_n_ff <= 1'b1;
            for (int i = 0; i < pscp_pkg::NVS_DEPTH; i++) begin
                nvs_ff[i] <= pscp_pkg::NVS_USER_INIT;
            end
            nvs_ff[0] <= pscp_pkg::NVS_WIPER_INIT;
            nvs_ff[pscp_pkg::OUTS_ADDR] <= pscp_pkg::NVS_OUTS_INIT;
        end else begin
            prev_ff <= lvl;
            sr_ff <= nxt_sr;
            cnt_ff <= nxt_cnt;
            seen_ff <= nxt_seen;
            sdo_ff <= nxt_sdo;
            last_ff <= nxt_last;
            have_ff <= nxt_have;
            boot_ff <= 1'b0;
            wiper_ff <= nxt_wiper;
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            done_n_ff <= nxt_done_n;
            nvs_ff <= nxt_nvs;
        end
    end

    // the raw pin is also used so the line lets go before the synchroniser catches up
    assign link.sdo_oe_n = link.cs_n | lvl[I_CS] | sdo_ff;
    assign link.sdo_o = 1'b0;
    assign wiper = wiper_ff;
    assign latched_out_one = nvs_ff[pscp_pkg::OUTS_ADDR][pscp_pkg::OUT_ONE_BIT];
    assign latched_out_two = nvs_ff[pscp_pkg::OUTS_ADDR][pscp_pkg::OUT_TWO_BIT];
    assign store_busy = (state_ff == PSCP_ST_STORE);
    assign store_done_n = done_n_ff;
endmodule : pscp_device
`default_nettype wire

// [hw/pscp_host.sv]
`timescale 1ns/1ns
`default_nettype none
module pscp_host #(
    parameter int HALF = pscp_pkg::SCLK_HALF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    pscp_if.host link,
    input wire logic start,
    input wire logic [pscp_pkg::NBITS_W-1:0] bit_count,
    input wire logic [pscp_pkg::MAX_BITS-1:0] tx_word,
    input wire logic mode_cpol,
    input wire logic protect,
    output logic [pscp_pkg::MAX_BITS-1:0] rx_word,
    output logic busy,
    output logic done
);
    typedef enum logic [4:0] {
        PSCP_H_IDLE = 5'b00001,
        PSCP_H_SETUP = 5'b00010,
        PSCP_H_LOW = 5'b00100,
        PSCP_H_HIGH = 5'b01000,
        PSCP_H_END = 5'b10000
    } pscp_hstate_t;

    localparam int TOP = pscp_pkg::MAX_BITS - 1;

    pscp_hstate_t st_ff, nxt_st;
    logic [7:0] div_ff, nxt_div;
    logic [pscp_pkg::NBITS_W-1:0] left_ff, nxt_left;
    logic [TOP:0] tx_ff, nxt_tx, rx_ff, nxt_rx;
    logic sclk_ff, nxt_sclk, cs_ff, nxt_cs, sdi_ff, nxt_sdi, cpol_ff, nxt_cpol;
    logic done_ff, nxt_done, wp_ff, nxt_wp, nop_ff, nxt_nop, sdo_lvl;

    pscp_sync #(
        .W(1),
        .INIT(1'b1)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(link.sdo),
        .level(sdo_lvl)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_div = (div_ff == 8'h00) ? div_ff : div_ff - 8'h01;
        nxt_left = left_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_sclk = sclk_ff;
        nxt_cs = cs_ff;
        nxt_sdi = sdi_ff;
        nxt_cpol = cpol_ff;
        nxt_done = 1'b0;
        nxt_nop = nop_ff;
        nxt_wp = protect ? 1'b0 : wp_ff;
        case (st_ff)
            PSCP_H_IDLE: begin
                nxt_sclk = mode_cpol;
                nxt_cpol = mode_cpol;
                // unprotecting waits for an idle command frame first
                if (!protect && !wp_ff) begin
                    nxt_nop = 1'b1;
                    nxt_tx = '0;
                    nxt_left = 6'(pscp_pkg::WORD_BITS);
                    nxt_st = PSCP_H_SETUP;
                end else if (start && sclk_ff == mode_cpol) begin
                    // a new clock mode must settle before select falls, or the far end counts an extra edge
                    nxt_tx = tx_word;
                    nxt_left = bit_count;
                    nxt_st = PSCP_H_SETUP;
                end
                if (nxt_st == PSCP_H_SETUP) begin
                    nxt_cs = 1'b0;
                    nxt_div = 8'(HALF - 1);
                end
            end
            PSCP_H_SETUP, PSCP_H_HIGH: begin
                if (div_ff == 8'h00) begin
                    if (st_ff == PSCP_H_HIGH) begin
                        nxt_rx = {rx_ff[TOP-1:0], sdo_lvl};
                        nxt_left = left_ff - 6'h01;
                    end
                    nxt_div = 8'(HALF - 1);
                    if (nxt_left == 6'h00) begin
                        // a zero-length frame is a bare select pulse
                        nxt_cs = 1'b1;
                        nxt_sclk = cpol_ff;
                        nxt_st = PSCP_H_END;
                    end else begin
                        nxt_sclk = 1'b0;
                        nxt_sdi = tx_ff[TOP];
                        nxt_tx = {tx_ff[TOP-1:0], 1'b0};
                        nxt_st = PSCP_H_LOW;
                    end
                end
            end
            PSCP_H_LOW: begin
                if (div_ff == 8'h00) begin
                    nxt_sclk = 1'b1;
                    nxt_div = 8'(HALF - 1);
                    nxt_st = PSCP_H_HIGH;
                end
            end
            PSCP_H_END: begin
                if (div_ff == 8'h00) begin
                    nxt_st = PSCP_H_IDLE;
                    nxt_done = 1'b1;
                    nxt_nop = 1'b0;
                    if (nop_ff) nxt_wp = 1'b1;
                end
            end
            default: nxt_st = PSCP_H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_ff <= PSCP_H_IDLE;
            div_ff <= '0;
            left_ff <= '0;
            tx_ff <= '0;
            rx_ff <= '0;
            sclk_ff <= 1'b0;
            cs_ff <= 1'b1;
            sdi_ff <= 1'b0;
            cpol_ff <= 1'b0;
            done_ff <= 1'b0;
            wp_ff <= 1'b1;
            nop_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            left_ff <= nxt_left;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            sclk_ff <= nxt_sclk;
            cs_ff <= nxt_cs;
            sdi_ff <= nxt_sdi;
            cpol_ff <= nxt_cpol;
            done_ff <= nxt_done;
            wp_ff <= nxt_wp;
            nop_ff <= nxt_nop;
        end
    end

    assign link.cs_n = cs_ff;
    assign link.sclk = sclk_ff;
    assign link.sdi = sdi_ff;
    assign link.wp_n = wp_ff;
    assign rx_word = rx_ff;
    assign busy = (st_ff != PSCP_H_IDLE);
    assign done = done_ff;
endmodule : pscp_host
`default_nettype wire

// [hw/pscp_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pscp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [W-1:0] nxt_lvl;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
            lvl_ff <= INIT;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level = lvl_ff;
endmodule : pscp_sync
`default_nettype wire

// [include/pscp_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface pscp_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic wp_n;
    logic sdo_o;
    logic sdo_oe_n;
    logic sdo;
    // open drain with pull-up: the line is low only while the device pulls it
    assign sdo = sdo_oe_n ? 1'b1 : sdo_o;
    modport dev (input cs_n, input sclk, input sdi, input wp_n, output sdo_o, output sdo_oe_n);
    modport host (output cs_n, output sclk, output sdi, output wp_n, input sdo);
endinterface : pscp_if
`default_nettype wire

// [include/pscp_pkg.sv]
package pscp_pkg;
    localparam int WORD_BITS = 24;
    localparam int CNT_W = 5;
    localparam int WIPER_W = 10;
    localparam int NVS_W = 16;
    localparam int NVS_DEPTH = 16;
    localparam int ADDR_W = 4;
    localparam int MAX_BITS = 48;
    localparam int NBITS_W = 6;
    // field positions inside the 24-bit word
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADR_MSB = 19;
    localparam int ADR_LSB = 16;
    localparam int DAT_MSB = 15;
    localparam int NIBBLE_MASK = 3;
    // command codes
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [3:0] CMD_RESTORE = 4'h1;
    localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
    localparam logic [3:0] CMD_STORE_DATA = 4'h3;
    localparam logic [3:0] CMD_DEC6_A = 4'h4;
    localparam logic [3:0] CMD_DEC6_B = 4'h5;
    localparam logic [3:0] CMD_DEC1_A = 4'h6;
    localparam logic [3:0] CMD_DEC1_B = 4'h7;
    localparam logic [3:0] CMD_RESET = 4'h8;
    localparam logic [3:0] CMD_READ_NVS = 4'h9;
    localparam logic [3:0] CMD_READ_WIPER = 4'hA;
    localparam logic [3:0] CMD_WRITE_WIPER = 4'hB;
    localparam logic [3:0] CMD_INC6_A = 4'hC;
    localparam logic [3:0] CMD_INC6_B = 4'hD;
    localparam logic [3:0] CMD_INC1_A = 4'hE;
    localparam logic [3:0] CMD_INC1_B = 4'hF;
    // reset values of the nonvolatile store and the wiper, the wiper top value, and the output latch address and bits
    localparam logic [9:0] WIPER_MID = 10'h200;
    localparam logic [9:0] WIPER_MAX = 10'h3FF;
    localparam logic [15:0] NVS_WIPER_INIT = 16'h0200;
    localparam logic [15:0] NVS_OUTS_INIT = 16'h0003;
    localparam logic [15:0] NVS_USER_INIT = 16'h0000;
    localparam logic [3:0] OUTS_ADDR = 4'h1;
    localparam int OUT_ONE_BIT = 0;
    localparam int OUT_TWO_BIT = 1;
    // timing
    localparam int SYS_CLK_KHZ = 20000;
    localparam int STORE_TIME_MS = 25;
    localparam int STORE_CYCLES = STORE_TIME_MS * SYS_CLK_KHZ;
    localparam int SCLK_HALF_CYCLES = 8;
    localparam int SYNC_STAGES = 3;
endpackage : pscp_pkg

// [tb/pot_serial_command_port_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module pot_serial_command_port_tb_top;
    localparam int LIMIT = 40000;
    logic sys_clk;
    logic reset_n;
    logic start;
    logic [pscp_pkg::NBITS_W-1:0] bit_count;
    logic [pscp_pkg::MAX_BITS-1:0] tx_word;
    logic mode_cpol;
    logic protect;
    logic reload_strobe_n;
    logic [pscp_pkg::MAX_BITS-1:0] rx_word;
    logic busy;
    logic done;
    logic [pscp_pkg::WIPER_W-1:0] wiper;
    logic latched_out_one;
    logic latched_out_two;
    logic store_busy;
    logic store_done_n;
    int error_cnt;
    int samples_checked;
    int cycles;
    pscp_if lnk();
    pscp_host i_pscp_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(lnk.host), .start(start),
        .bit_count(bit_count), .tx_word(tx_word), .mode_cpol(mode_cpol), .protect(protect),
        .rx_word(rx_word), .busy(busy), .done(done));
    // short store time keeps the run brief
    pscp_device #(.STORE_CYCLES(50)) i_pscp_device (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(lnk.dev), .reload_strobe_n(reload_strobe_n), .wiper(wiper),
        .latched_out_one(latched_out_one), .latched_out_two(latched_out_two),
        .store_busy(store_busy), .store_done_n(store_done_n));
    pscp_asserts i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .sdi(lnk.sdi), .wp_n(lnk.wp_n), .sdo_o(lnk.sdo_o), .sdo_oe_n(lnk.sdo_oe_n), .sdo(lnk.sdo));
    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic frame(input int n, input logic [47:0] w, input logic m);
        int k;
        @(posedge sys_clk);
        mode_cpol <= m;
        // the idle clock level moves while select is still high
        repeat (4) @(posedge sys_clk);
        start <= 1'b1;
        bit_count <= n[5:0];
        tx_word <= w;
        @(posedge sys_clk);
        start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 3000) begin
            error_cnt++;
        end
        // decode lands a few cycles after select rises, before done is seen
        repeat (10) @(negedge sys_clk);
    endtask : frame
    task automatic f24(input logic [23:0] w, input logic m);
        frame(24, {w, 24'h000000}, m);
    endtask : f24
    task automatic wipe(input logic [9:0] exp);
        chk(48'(wiper), 48'(exp));
    endtask : wipe
    task automatic wait_store();
        int k;
        k = 0;
        while (store_done_n !== 1'b0 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        chk(48'(store_done_n), 48'h0);
        @(negedge sys_clk);
        chk(48'(store_busy), 48'h0);
    endtask : wait_store
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    initial begin
        int k;
        reset_n = 1'b0;
        start = 1'b0;
        bit_count = 6'h00;
        tx_word = 48'h0;
        mode_cpol = 1'b0;
        protect = 1'b0;
        reload_strobe_n = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(negedge sys_clk);
        wipe(10'h200);
        chk({46'h0, latched_out_two, latched_out_one}, 48'h3);
        f24(24'hB0FD55, 1'b0);
        wipe(10'h155);
        f24(24'hB10066, 1'b0);
        wipe(10'h155);
        f24(24'hB00321, 1'b1);
        wipe(10'h321);
        f24(24'hA00000, 1'b1);
        f24(24'h000000, 1'b0);
        chk({24'h0, rx_word[23:0]}, 48'hA00321);
        // one device sees both words: first passes through, second is kept
        frame(48, {24'hB00011, 24'hB00222}, 1'b0);
        wipe(10'h222);
        chk(rx_word, {24'h000000, 24'hB00011});
        f24(24'hE00000, 1'b0);
        wipe(10'h223);
        frame(0, 48'h0, 1'b0);
        wipe(10'h224);
        f24(24'h400000, 1'b0);
        wipe(10'h112);
        frame(22, {24'hB00050, 24'h0}, 1'b0);
        wipe(10'h112);
        frame(20, {24'hB00050, 24'h0}, 1'b0);
        wipe(10'h112);
        f24(24'hB00050, 1'b0);
        wipe(10'h050);
        @(posedge sys_clk);
        protect <= 1'b1;
        repeat (10) @(negedge sys_clk);
        f24(24'hB00333, 1'b0);
        wipe(10'h050);
        f24(24'hC00000, 1'b1);
        wipe(10'h050);
        f24(24'h800000, 1'b0);
        wipe(10'h200);
        @(posedge sys_clk);
        protect <= 1'b0;
        k = 0;
        while ((lnk.wp_n !== 1'b1 || busy !== 1'b0) && k < 2000) begin
            @(negedge sys_clk);
            k++;
        end
        chk(48'(lnk.wp_n), 48'h1);
        f24(24'hB000AB, 1'b0);
        f24(24'h200000, 1'b0);
        chk(48'(store_busy), 48'h1);
        wait_store();
        f24(24'hB00011, 1'b0);
        @(posedge sys_clk);
        reload_strobe_n <= 1'b0;
        repeat (10) @(negedge sys_clk);
        wipe(10'h200);
        @(posedge sys_clk);
        reload_strobe_n <= 1'b1;
        repeat (10) @(negedge sys_clk);
        wipe(10'h0AB);
        f24(24'h600000, 1'b0);
        wipe(10'h0AA);
        f24(24'hC00000, 1'b0);
        wipe(10'h154);
        f24(24'h100000, 1'b0);
        wipe(10'h0AB);
        f24(24'h310002, 1'b0);
        wait_store();
        chk({46'h0, latched_out_two, latched_out_one}, 48'h2);
        f24(24'h910000, 1'b1);
        f24(24'h000000, 1'b1);
        chk({24'h0, rx_word[23:0]}, 48'h910002);
        end_sim();
    end
endmodule : pot_serial_command_port_tb_top
`default_nettype wire

// [tb/pscp_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module pscp_asserts (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic wp_n,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    input wire logic sdo
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // set at frame start, cleared by any one bit shifted in: tells an all-zero frame
    logic zero_ff;
    logic cs_q_ff;
    logic sclk_q_ff;
    logic nxt_zero;
    always_comb begin
        nxt_zero = zero_ff;
        if (!cs_n && cs_q_ff) begin
            nxt_zero = 1'b1;
        end else if (!cs_n && sclk && !sclk_q_ff && sdi) begin
            nxt_zero = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            zero_ff <= 1'b0;
            cs_q_ff <= 1'b1;
            sclk_q_ff <= 1'b0;
        end else begin
            zero_ff <= nxt_zero;
            cs_q_ff <= cs_n;
            sclk_q_ff <= sclk;
        end
    end
    a_sdo_released: assert property (cs_n && $past(cs_n) |-> sdo_oe_n && sdo)
        else $error("data out pulled low while deselected");
    a_pull_value_low: assert property (sdo_o == 1'b0)
        else $error("open drain pull value not low");
    a_sclk_high_half: assert property (!cs_n && $rose(sclk) |=> $stable(sclk) [*7])
        else $error("serial clock high phase too short");
    a_sdi_steady_high: assert property (!cs_n && sclk && $past(sclk) && !$past(cs_n) |-> $stable(sdi))
        else $error("data in moved while clock high");
    a_sdo_steady_high: assert property (sclk && $past(sclk) && !cs_n && !$past(cs_n, 7) |-> $stable(sdo))
        else $error("data out moved while clock high");
    a_cs_held_frame: assert property (!cs_n && $rose(sclk) |=> !cs_n [*7])
        else $error("select released inside a clock high phase");
    a_cs_high_gap: assert property ($rose(cs_n) |-> cs_n [*5])
        else $error("select high gap too short");
    a_unprotect_idle: assert property ($rose(wp_n) |-> cs_n && zero_ff)
        else $error("protect released without idle frame");
endmodule : pscp_asserts
`default_nettype wire
